/* mmvi_top.v */
// video input front end: pixel timing, column demux, config registers
`timescale 1ns/10ps
`default_nettype none
`include "mmvi_defs.vh"

// What this block does
// - address full 680x520 array, both scan directions
// - odd columns top sequencer, even bottom
// - three 10-bit sub-pixel data buses
// - mono mode uses one 10-bit path
// - mono copies value to three columns
// - source clocks and syncs drive timing
// - register selects progressive or interlaced scan
// - serial slave only, address LSB pin
// - serial master reads and writes registers
// - reset low blanks display, loads register defaults
// - pixels loaded only while data valid
// - burn-in while select high, default off
// - accept 640x480 active video format
// - register-selected test pattern replaces video
// - enable low stops row/column sequencers
// - reset active low, async, default released
module mmvi_top (
	input  wire       clk,
	input  wire       reset,
	input  wire       hw_reset_n,
	input  wire       pix_clk,
	input  wire       hsync,
	input  wire       vsync,
	input  wire       pixel_data_valid,
	input  wire [9:0] unused_red_bus,
	input  wire [9:0] mono_pixel_bus,
	input  wire [9:0] unused_blue_bus,
	input  wire       enable,
	input  wire       burn_in_select,
	input  wire       serial_addr_lsb_pin,
	input  wire       scl,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	output wire [9:0] sub_r_data,
	output wire [9:0] sub_g_data,
	output wire [9:0] sub_b_data,
	output wire [9:0] col_addr,
	output wire [9:0] row_addr,
	output wire       col_we_top,
	output wire       col_we_bot,
	output wire [2:0] chan_pwr_en,
	output wire       display_on,
	output wire       field_odd,
	output wire       line_start,
	output wire       frame_start,
	output wire       burn_in_active
);
	// pin synchronisers: [0] first stage, [1] second, pix clock [2] for edges
	reg  [2:0]  pc_s_q;
	reg  [1:0]  hs_s_q;
	reg  [1:0]  vs_s_q;
	reg  [1:0]  de_s_q;
	reg  [1:0]  en_s_q;
	reg  [1:0]  bi_s_q;
	reg  [1:0]  sa_s_q;
	reg  [29:0] bus_s0_q;
	reg  [29:0] bus_s1_q;
	// configuration
	reg  [7:0]  mode_q;
	reg  [7:0]  hsh_q;
	reg  [7:0]  vsh_q;
	reg  [7:0]  tpl_q;
	reg  [7:0]  rd_d;
	// timing state
	reg         hs_prev_q;
	reg         vs_prev_q;
	reg  [9:0]  pix_q;
	reg  [9:0]  line_q;
	reg         had_de_q;
	reg         field_q;
	// outputs
	reg  [9:0]  r_q;
	reg  [9:0]  g_q;
	reg  [9:0]  b_q;
	reg  [9:0]  ca_q;
	reg  [9:0]  ra_q;
	reg         we_top_q;
	reg         we_bot_q;
	reg         ls_q;
	reg         fs_q;

	wire        wr_stb;
	wire [7:0]  wr_addr;
	wire [7:0]  wr_data;
	wire [7:0]  rd_addr;
	wire        pc_rise;
	wire        hs_start;
	wire        vs_start;
	wire        run;
	wire        mono;
	wire        intl;
	wire [7:0]  hsh_c;
	wire [7:0]  vsh_c;
	wire [9:0]  row_act;
	wire [9:0]  col_raw;
	wire [9:0]  row_raw;
	wire [9:0]  col_fin;
	wire [9:0]  row_fin;
	wire        in_fmt;
	wire        tp_on;
	wire [9:0]  tp_val;
	wire [9:0]  r_in;
	wire [9:0]  g_in;
	wire [9:0]  b_in;
	wire [9:0]  r_pix;
	wire [9:0]  g_pix;
	wire [9:0]  b_pix;

	mmvi_i2c u_i2c (
		.clk        (clk),
		.reset      (reset),
		.hw_reset_n (hw_reset_n),
		.scl_in     (scl),
		.sda_in     (sda_in),
		.sda_out    (sda_out),
		.sda_oe     (sda_oe),
		.addr_lsb   (sa_s_q[1]),
		.wr_stb     (wr_stb),
		.wr_addr    (wr_addr),
		.wr_data    (wr_data),
		.rd_addr    (rd_addr),
		.rd_data    (rd_d)
	);

	assign mono    = mode_q[`MMVI_MODE_MONO];
	assign intl    = mode_q[`MMVI_MODE_INTL];
	assign tp_on   = mode_q[`MMVI_MODE_TP];
	// one sample per pixel clock rising edge
	assign pc_rise = pc_s_q[1] & ~pc_s_q[2];
	assign hs_start = hs_s_q[1] & ~hs_prev_q;
	assign vs_start = vs_s_q[1] & ~vs_prev_q;
	// enable low freezes counters and strobes
	assign run     = pc_rise & en_s_q[1];

	// shifts above the 40 spare lines would run off the array
	assign hsh_c   = (hsh_q > `MMVI_MAX_SHIFT) ? `MMVI_MAX_SHIFT : hsh_q;
	assign vsh_c   = (vsh_q > `MMVI_MAX_SHIFT) ? `MMVI_MAX_SHIFT : vsh_q;
	// interlaced rows interleave the two fields
	assign row_act = intl ? {line_q[8:0], field_q} : line_q;
	assign col_raw = pix_q + {2'b00, hsh_c};
	assign row_raw = row_act + {2'b00, vsh_c};
	// either scan direction over the full array
	assign col_fin = mode_q[`MMVI_MODE_CREV] ? (`MMVI_ARR_COL_LAST - col_raw) : col_raw;
	assign row_fin = mode_q[`MMVI_MODE_RREV] ? (`MMVI_ARR_ROW_LAST - row_raw) : row_raw;
	assign in_fmt  = (pix_q < `MMVI_ACT_COLS) && (row_act < `MMVI_ACT_ROWS);

	// checkerboard of the programmed level and black
	assign tp_val  = (pix_q[`MMVI_TP_BIT] ^ row_act[`MMVI_TP_BIT]) ?
	                 {tpl_q, 2'b00} : `MMVI_PIX_ZERO;
	assign r_in    = bus_s1_q[29:20];
	assign g_in    = bus_s1_q[19:10];
	assign b_in    = bus_s1_q[9:0];
	// mono takes green only and fans it out to all three columns
	assign g_pix   = tp_on ? tp_val : g_in;
	assign r_pix   = tp_on ? tp_val : (mono ? g_in : r_in);
	assign b_pix   = tp_on ? tp_val : (mono ? g_in : b_in);

	assign sub_r_data     = r_q;
	assign sub_g_data     = g_q;
	assign sub_b_data     = b_q;
	assign col_addr       = ca_q;
	assign row_addr       = ra_q;
	assign col_we_top     = we_top_q;
	assign col_we_bot     = we_bot_q;
	assign line_start     = ls_q;
	assign frame_start    = fs_q;
	assign field_odd      = field_q;
	assign display_on     = mode_q[`MMVI_MODE_ON];
	assign burn_in_active = bi_s_q[1];
	assign chan_pwr_en    = mono ? `MMVI_PWR_MONO : `MMVI_PWR_ALL;

	// register read mux; unmapped offsets read zero
	always @* begin
		rd_d = `MMVI_BYTE_ZERO;
		case (rd_addr)
		`MMVI_REG_MODE:    rd_d = mode_q;
		`MMVI_REG_HSHIFT:  rd_d = hsh_q;
		`MMVI_REG_VSHIFT:  rd_d = vsh_q;
		`MMVI_REG_TPLEVEL: rd_d = tpl_q;
		`MMVI_REG_STATUS:  rd_d = {5'h00, field_q, en_s_q[1], bi_s_q[1]};
		`MMVI_REG_LINECNT: rd_d = line_q[7:0];
		default:           rd_d = `MMVI_BYTE_ZERO;
		endcase
	end

	// async clear takes constants only; display starts off
	always @(posedge clk or negedge hw_reset_n) begin
		if (!hw_reset_n) begin
			mode_q <= `MMVI_MODE_RST;
			hsh_q  <= `MMVI_SHIFT_RST;
			vsh_q  <= `MMVI_SHIFT_RST;
			tpl_q  <= `MMVI_TPLEVEL_RST;
		end else if (reset) begin
			mode_q <= `MMVI_MODE_RST;
			hsh_q  <= `MMVI_SHIFT_RST;
			vsh_q  <= `MMVI_SHIFT_RST;
			tpl_q  <= `MMVI_TPLEVEL_RST;
		end else if (wr_stb) begin
			case (wr_addr)
			`MMVI_REG_MODE:    mode_q <= wr_data;
			`MMVI_REG_HSHIFT:  hsh_q  <= wr_data;
			`MMVI_REG_VSHIFT:  vsh_q  <= wr_data;
			`MMVI_REG_TPLEVEL: tpl_q  <= wr_data;
			default:           mode_q <= mode_q;
			endcase
		end
	end

	// two-flop synchronisers for every pin; address pin assumed driven
	always @(posedge clk or negedge hw_reset_n) begin
		if (!hw_reset_n) begin
			pc_s_q   <= 3'h7; // idle high: a clock standing high at release is no rise
			hs_s_q   <= 2'h0;
			vs_s_q   <= 2'h0;
			de_s_q   <= 2'h0;
			en_s_q   <= 2'h0;
			bi_s_q   <= 2'h0;
			sa_s_q   <= 2'h0;
			bus_s0_q <= 30'h0000_0000;
			bus_s1_q <= 30'h0000_0000;
		end else if (reset) begin
			pc_s_q   <= 3'h7;
			hs_s_q   <= 2'h0;
			vs_s_q   <= 2'h0;
			de_s_q   <= 2'h0;
			en_s_q   <= 2'h0;
			bi_s_q   <= 2'h0;
			sa_s_q   <= 2'h0;
			bus_s0_q <= 30'h0000_0000;
			bus_s1_q <= 30'h0000_0000;
		end else begin
			pc_s_q   <= {pc_s_q[1:0], pix_clk};
			hs_s_q   <= {hs_s_q[0], hsync};
			vs_s_q   <= {vs_s_q[0], vsync};
			de_s_q   <= {de_s_q[0], pixel_data_valid};
			en_s_q   <= {en_s_q[0], enable};
			bi_s_q   <= {bi_s_q[0], burn_in_select};
			sa_s_q   <= {sa_s_q[0], serial_addr_lsb_pin};
			bus_s0_q <= {unused_red_bus, mono_pixel_bus, unused_blue_bus};
			bus_s1_q <= bus_s0_q;
		end
	end

	// pixel and line counters, strobes to the column sequencers
	always @(posedge clk or negedge hw_reset_n) begin
		if (!hw_reset_n) begin
			hs_prev_q <= 1'b0;
			vs_prev_q <= 1'b0;
			pix_q     <= `MMVI_CNT_ZERO;
			line_q    <= `MMVI_CNT_ZERO;
			had_de_q  <= 1'b0;
			field_q   <= 1'b0;
			r_q       <= `MMVI_PIX_ZERO;
			g_q       <= `MMVI_PIX_ZERO;
			b_q       <= `MMVI_PIX_ZERO;
			ca_q      <= `MMVI_CNT_ZERO;
			ra_q      <= `MMVI_CNT_ZERO;
			we_top_q  <= 1'b0;
			we_bot_q  <= 1'b0;
			ls_q      <= 1'b0;
			fs_q      <= 1'b0;
		end else if (reset) begin
			hs_prev_q <= 1'b0;
			vs_prev_q <= 1'b0;
			pix_q     <= `MMVI_CNT_ZERO;
			line_q    <= `MMVI_CNT_ZERO;
			had_de_q  <= 1'b0;
			field_q   <= 1'b0;
			r_q       <= `MMVI_PIX_ZERO;
			g_q       <= `MMVI_PIX_ZERO;
			b_q       <= `MMVI_PIX_ZERO;
			ca_q      <= `MMVI_CNT_ZERO;
			ra_q      <= `MMVI_CNT_ZERO;
			we_top_q  <= 1'b0;
			we_bot_q  <= 1'b0;
			ls_q      <= 1'b0;
			fs_q      <= 1'b0;
		end else begin
			we_top_q <= 1'b0;
			we_bot_q <= 1'b0;
			ls_q     <= 1'b0;
			fs_q     <= 1'b0;
			if (run) begin
				hs_prev_q <= hs_s_q[1];
				vs_prev_q <= vs_s_q[1];
				if (vs_start) begin
					// frame restart; field alternates only when interlaced
					pix_q    <= `MMVI_CNT_ZERO;
					line_q   <= `MMVI_CNT_ZERO;
					had_de_q <= 1'b0;
					field_q  <= intl & ~field_q;
					fs_q     <= 1'b1;
				end else if (hs_start) begin
					pix_q    <= `MMVI_CNT_ZERO;
					had_de_q <= 1'b0;
					ls_q     <= 1'b1;
					if (had_de_q) begin
						line_q <= line_q + `MMVI_CNT_ONE;
					end
				end else if (de_s_q[1]) begin
					// only data-valid pixels load a column
					pix_q    <= pix_q + `MMVI_CNT_ONE;
					had_de_q <= 1'b1;
					if (in_fmt) begin
						ca_q     <= col_fin;
						ra_q     <= row_fin;
						// column number is index+1: even index is an odd column
						we_top_q <= ~col_fin[0];
						we_bot_q <= col_fin[0];
						if (bi_s_q[1]) begin
							// burn-in drives every sub-pixel full scale
							r_q <= `MMVI_PIX_FULL;
							g_q <= `MMVI_PIX_FULL;
							b_q <= `MMVI_PIX_FULL;
						end else if (!mode_q[`MMVI_MODE_ON]) begin
							// blanked while the display is off
							r_q <= `MMVI_PIX_ZERO;
							g_q <= `MMVI_PIX_ZERO;
							b_q <= `MMVI_PIX_ZERO;
						end else begin
							r_q <= r_pix;
							g_q <= g_pix;
							b_q <= b_pix;
						end
					end
				end
			end
		end
	end
endmodule

`default_nettype wire

/* mmvi_defs.vh */
// shared constants for the monochrome microdisplay video input block
`ifndef MMVI_DEFS_VH
`define MMVI_DEFS_VH

// configuration register offsets
`define MMVI_REG_MODE    8'h00
`define MMVI_REG_HSHIFT  8'h01
`define MMVI_REG_VSHIFT  8'h02
`define MMVI_REG_TPLEVEL 8'h03
`define MMVI_REG_STATUS  8'h04
`define MMVI_REG_LINECNT 8'h05

// display_mode_reg bit positions
`define MMVI_MODE_ON   0
`define MMVI_MODE_INTL 1
`define MMVI_MODE_MONO 2
`define MMVI_MODE_TP   3
`define MMVI_MODE_CREV 4
`define MMVI_MODE_RREV 5

// reset values
`define MMVI_MODE_RST    8'h04
`define MMVI_SHIFT_RST   8'h14
`define MMVI_TPLEVEL_RST 8'hff
`define MMVI_BYTE_ZERO   8'h00

// array and active format
`define MMVI_ACT_COLS     10'h280
`define MMVI_ACT_ROWS     10'h1e0
`define MMVI_ARR_COLS     10'h2a8
`define MMVI_ARR_ROWS     10'h208
`define MMVI_ARR_COL_LAST 10'h2a7
`define MMVI_ARR_ROW_LAST 10'h207
`define MMVI_MAX_SHIFT    8'h28
`define MMVI_PIX_FULL     10'h3ff
`define MMVI_PIX_ZERO     10'h000
`define MMVI_CNT_ZERO     10'h000
`define MMVI_CNT_ONE      10'h001
`define MMVI_TP_BIT       5

// channel power enables, bit 1 is the green path
`define MMVI_PWR_ALL  3'h7
`define MMVI_PWR_MONO 3'h2

// serial slave: upper six address bits, value is arbitrary
`define MMVI_I2C_BASE 6'h1d
`define MMVI_I2C_BITS 4'h8
`define MMVI_BC_ZERO  4'h0
`define MMVI_BC_ONE   4'h1
`define MMVI_PTR_ONE  8'h01

// serial slave states
`define MMVI_ST_IDLE 3'h0
`define MMVI_ST_ADDR 3'h1
`define MMVI_ST_AACK 3'h2
`define MMVI_ST_WR   3'h3
`define MMVI_ST_WACK 3'h4
`define MMVI_ST_RD   3'h5
`define MMVI_ST_RACK 3'h6

`endif

/* mmvi_i2c.v */
// two-wire slave giving read and write access to the configuration registers
`timescale 1ns/10ps
`default_nettype none
`include "mmvi_defs.vh"

module mmvi_i2c (
	input  wire       clk,
	input  wire       reset,
	input  wire       hw_reset_n,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	input  wire       addr_lsb,
	output wire       wr_stb,
	output wire [7:0] wr_addr,
	output wire [7:0] wr_data,
	output wire [7:0] rd_addr,
	input  wire [7:0] rd_data
);
	reg  [2:0] scl_s_q;
	reg  [2:0] sda_s_q;
	reg  [2:0] st_q;
	reg  [7:0] sh_q;
	reg  [3:0] bc_q;
	reg        rw_q;
	reg        first_q;
	reg        oe_q;
	reg        wr_q;
	reg  [7:0] wa_q;
	reg  [7:0] wd_q;
	reg  [7:0] ptr_q;
	wire       scl_r;
	wire       scl_f;
	wire       start;
	wire       stop;
	wire       sda_b;

	// stage 0 is read only by stage 1; 400 kHz max leaves ~50 samples a bit
	assign scl_r = scl_s_q[1] & ~scl_s_q[2];
	assign scl_f = ~scl_s_q[1] & scl_s_q[2];
	assign sda_b = sda_s_q[1];
	assign start = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
	assign stop  = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

	// open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe  = oe_q;
	assign wr_stb  = wr_q;
	assign wr_addr = wa_q;
	assign wr_data = wd_q;
	assign rd_addr = ptr_q;

	always @(posedge clk or negedge hw_reset_n) begin
		if (!hw_reset_n) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			st_q    <= `MMVI_ST_IDLE;
			sh_q    <= `MMVI_BYTE_ZERO;
			bc_q    <= `MMVI_BC_ZERO;
			rw_q    <= 1'b0;
			first_q <= 1'b0;
			oe_q    <= 1'b0;
			wr_q    <= 1'b0;
			wa_q    <= `MMVI_BYTE_ZERO;
			wd_q    <= `MMVI_BYTE_ZERO;
			ptr_q   <= `MMVI_BYTE_ZERO;
		end else if (reset) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			st_q    <= `MMVI_ST_IDLE;
			sh_q    <= `MMVI_BYTE_ZERO;
			bc_q    <= `MMVI_BC_ZERO;
			rw_q    <= 1'b0;
			first_q <= 1'b0;
			oe_q    <= 1'b0;
			wr_q    <= 1'b0;
			wa_q    <= `MMVI_BYTE_ZERO;
			wd_q    <= `MMVI_BYTE_ZERO;
			ptr_q   <= `MMVI_BYTE_ZERO;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_in};
			sda_s_q <= {sda_s_q[1:0], sda_in};
			wr_q    <= 1'b0;
			if (start) begin
				st_q <= `MMVI_ST_ADDR;
				bc_q <= `MMVI_BC_ZERO;
				oe_q <= 1'b0;
			end else if (stop) begin
				st_q <= `MMVI_ST_IDLE;
				oe_q <= 1'b0;
			end else begin
				case (st_q)
				`MMVI_ST_ADDR: begin
					if (scl_r) begin
						sh_q <= {sh_q[6:0], sda_b};
						bc_q <= bc_q + `MMVI_BC_ONE;
					end else if (scl_f && bc_q == `MMVI_I2C_BITS) begin
						// slave only; low address bit taken from the pin
						if (sh_q[7:1] == {`MMVI_I2C_BASE, addr_lsb}) begin
							oe_q    <= 1'b1;
							rw_q    <= sh_q[0];
							first_q <= 1'b1;
							st_q    <= `MMVI_ST_AACK;
						end else begin
							st_q <= `MMVI_ST_IDLE;
						end
					end
				end
				`MMVI_ST_AACK: begin
					if (scl_f) begin
						bc_q <= `MMVI_BC_ZERO;
						if (rw_q) begin
							sh_q  <= rd_data;
							ptr_q <= ptr_q + `MMVI_PTR_ONE;
							oe_q  <= ~rd_data[7];
							st_q  <= `MMVI_ST_RD;
						end else begin
							oe_q <= 1'b0;
							st_q <= `MMVI_ST_WR;
						end
					end
				end
				`MMVI_ST_WR: begin
					if (scl_r) begin
						sh_q <= {sh_q[6:0], sda_b};
						bc_q <= bc_q + `MMVI_BC_ONE;
					end else if (scl_f && bc_q == `MMVI_I2C_BITS) begin
						oe_q    <= 1'b1;
						first_q <= 1'b0;
						st_q    <= `MMVI_ST_WACK;
						if (first_q) begin
							ptr_q <= sh_q;
						end else begin
							wr_q  <= 1'b1;
							wa_q  <= ptr_q;
							wd_q  <= sh_q;
							ptr_q <= ptr_q + `MMVI_PTR_ONE;
						end
					end
				end
				`MMVI_ST_WACK: begin
					if (scl_f) begin
						oe_q <= 1'b0;
						bc_q <= `MMVI_BC_ZERO;
						st_q <= `MMVI_ST_WR;
					end
				end
				`MMVI_ST_RD: begin
					if (scl_r) begin
						bc_q <= bc_q + `MMVI_BC_ONE;
					end else if (scl_f) begin
						if (bc_q == `MMVI_I2C_BITS) begin
							oe_q <= 1'b0;
							st_q <= `MMVI_ST_RACK;
						end else begin
							sh_q <= {sh_q[6:0], 1'b0};
							oe_q <= ~sh_q[6];
						end
					end
				end
				`MMVI_ST_RACK: begin
					if (scl_r && sda_b) begin
						st_q <= `MMVI_ST_IDLE;
					end else if (scl_f) begin
						sh_q  <= rd_data;
						ptr_q <= ptr_q + `MMVI_PTR_ONE;
						oe_q  <= ~rd_data[7];
						bc_q  <= `MMVI_BC_ZERO;
						st_q  <= `MMVI_ST_RD;
					end
				end
				default: begin
					oe_q <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule

`default_nettype wire

/* mmvi_chk_props.sv */
// assertion checker on the ports of the video input front end
`timescale 1ns/10ps
`default_nettype none
module mmvi_chk (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       hw_reset_n,
	input wire logic       enable,
	input wire logic       col_we_top,
	input wire logic       col_we_bot,
	input wire logic [9:0] col_addr,
	input wire logic [9:0] row_addr,
	input wire logic [9:0] sub_r_data,
	input wire logic [9:0] sub_g_data,
	input wire logic [9:0] sub_b_data,
	input wire logic [2:0] chan_pwr_en,
	input wire logic       display_on,
	input wire logic       burn_in_active,
	input wire logic       line_start,
	input wire logic       frame_start
);
	wire we = col_we_top || col_we_bot;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	one_side_a: assert property (!(col_we_top && col_we_bot))
		else $error("both column strobes high");
	top_even_a: assert property (col_we_top |-> !col_addr[0])
		else $error("top strobe on odd index");
	bot_odd_a: assert property (col_we_bot |-> col_addr[0])
		else $error("bottom strobe on even index");
	array_bound_a: assert property (we |-> col_addr <= 10'h2a7 && row_addr <= 10'h207)
		else $error("address outside array");
	mono_copy_a: assert property (we && chan_pwr_en == 3'h2 |->
		sub_r_data == sub_g_data && sub_b_data == sub_g_data)
		else $error("mono columns differ");
	blank_off_a: assert property (we && !display_on && !$past(display_on) && !burn_in_active
		&& !$past(burn_in_active) |-> sub_g_data == 10'h000)
		else $error("data while display off");
	burn_full_a: assert property (we && burn_in_active && $past(burn_in_active)
		|-> sub_g_data == 10'h3ff)
		else $error("burn-in data not full");
	strobe_pulse_a: assert property ($rose(we) |=> !we)
		else $error("strobe longer than one cycle");
	hold_off_a: assert property (!enable [*5] |-> !we)
		else $error("write while disabled");
	frame_line_a: assert property (frame_start |-> !line_start)
		else $error("line start with frame start");
	reset_dark_a: assert property (!hw_reset_n |-> !display_on && !we && chan_pwr_en == 3'h2)
		else $error("reset did not blank");
	cover property (col_we_top);
	cover property (col_we_bot);
	cover property (frame_start);
	cover property (we && burn_in_active);
endmodule
bind mmvi_top mmvi_chk u_chk (.clk(clk), .reset(reset), .hw_reset_n(hw_reset_n),
	.enable(enable), .col_we_top(col_we_top), .col_we_bot(col_we_bot), .col_addr(col_addr),
	.row_addr(row_addr), .sub_r_data(sub_r_data), .sub_g_data(sub_g_data),
	.sub_b_data(sub_b_data), .chan_pwr_en(chan_pwr_en), .display_on(display_on),
	.burn_in_active(burn_in_active), .line_start(line_start), .frame_start(frame_start));
`default_nettype wire

/* mmvi_src.sv */
// video source and two-wire configuration master model
`timescale 1ns/10ps
`default_nettype none
module mmvi_src (
	input  wire logic       clk,
	output var  logic       pix_clk,
	output var  logic       hsync,
	output var  logic       vsync,
	output var  logic       de,
	output var  logic [9:0] green,
	output var  logic [9:0] red,
	output var  logic [9:0] blue,
	output var  logic       scl,
	output wire logic       sda,
	input  wire logic       dev_sda_oe,
	input  wire logic       dev_sda_out
);
	logic m_low = 1'b0;
	// pull-up: wire low only while some party pulls a low level
	assign sda = !(m_low || (dev_sda_oe && !dev_sda_out));
	initial begin
		pix_clk = 1'b0;
		hsync = 1'b0;
		vsync = 1'b0;
		de = 1'b0;
		green = 10'h000;
		red = 10'h000;
		blue = 10'h000;
		scl = 1'b1;
	end
	// colour-only buses, left at ground for mono
	task automatic rb(input logic [9:0] r, input logic [9:0] b);
		red = r;
		blue = b;
	endtask
	// everything launched just after a clk edge, same domain
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// values are already gamma corrected by the caller
	task automatic pix(input logic d, input logic hs, input logic vs, input logic [9:0] g);
		pix_clk = 1'b0;
		de = d;
		hsync = hs;
		vsync = vs;
		green = g;
		w(4);
		pix_clk = 1'b1;
		w(4);
	endtask
	// 26 clk per half period keeps the serial clock under 400 kHz
	task automatic start;
		m_low = 1'b0;
		w(13);
		scl = 1'b1;
		w(13);
		m_low = 1'b1;
		w(13);
		scl = 1'b0;
	endtask
	task automatic stop;
		w(13);
		m_low = 1'b1;
		w(13);
		scl = 1'b1;
		w(13);
		m_low = 1'b0;
		w(13);
	endtask
	// sending 8'hff releases the line, so the same task reads
	task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
		output logic ack);
		logic [8:0] sh;
		sh = 9'h000;
		for (int i = 0; i < 9; i++) begin
			w(13);
			m_low = (i < 8) ? !d[7 - i] : !ab;
			w(13);
			scl = 1'b1;
			w(13);
			sh = {sh[7:0], sda};
			w(13);
			scl = 1'b0;
		end
		q = sh[8:1];
		ack = sh[0];
	endtask
endmodule
`default_nettype wire

/* tb_mmvi_top.sv */
// self-checking bench for the video input front end
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("CHECK FAILED %0t %s", $time, m); end end
module tb_mmvi_top;
	typedef struct {logic [9:0] g; logic de; logic we; logic [9:0] col; logic top;} mmvi_row_t;
	logic       clk = 1'b0, reset = 1'b1, hw_reset_n = 1'b1, enable = 1'b1, bi = 1'b0, pin = 1'b1;
	wire logic  pix_clk, hsync, vsync, de, scl, sda, sda_oe, we_t, we_b;
	wire logic  display_on, field_odd, burn_in_active, sda_o, ls, fs;
	wire logic  [9:0] red, green, blue, r_o, g_o, b_o, col, row;
	wire logic  [2:0] pwr;
	int         num_errors = 0, checked = 0, n_wr = 0, n0, n_ls = 0, n_fs = 0;
	logic [9:0] l_col, l_row, l_r, l_g, l_b;
	logic       l_top, ak;
	logic [7:0] q;
	mmvi_row_t  rows [4] = '{'{10'h155, 1'b1, 1'b1, 10'h014, 1'b1},
		'{10'h2aa, 1'b0, 1'b0, 10'h000, 1'b0}, '{10'h3ff, 1'b1, 1'b1, 10'h015, 1'b0},
		'{10'h000, 1'b1, 1'b1, 10'h016, 1'b1}};
	mmvi_src src (.clk(clk), .pix_clk(pix_clk), .hsync(hsync), .vsync(vsync), .de(de),
		.green(green), .red(red), .blue(blue), .scl(scl), .sda(sda), .dev_sda_oe(sda_oe),
		.dev_sda_out(sda_o));
	mmvi_top uut (.clk(clk), .reset(reset), .hw_reset_n(hw_reset_n), .pix_clk(pix_clk),
		.hsync(hsync), .vsync(vsync), .pixel_data_valid(de), .unused_red_bus(red),
		.mono_pixel_bus(green), .unused_blue_bus(blue), .enable(enable), .burn_in_select(bi),
		.serial_addr_lsb_pin(pin), .scl(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe),
		.sub_r_data(r_o), .sub_g_data(g_o), .sub_b_data(b_o), .col_addr(col), .row_addr(row),
		.col_we_top(we_t), .col_we_bot(we_b), .chan_pwr_en(pwr), .display_on(display_on),
		.field_odd(field_odd), .line_start(ls), .frame_start(fs), .burn_in_active(burn_in_active));
	always #25 clk = ~clk;
	always @(posedge clk) begin
		n_ls += (ls === 1'b1);
		n_fs += (fs === 1'b1);
		if (we_t || we_b) begin
			n_wr++;
			{l_col, l_row, l_r, l_g, l_b, l_top} = {col, row, r_o, g_o, b_o, we_t};
		end
	end
	task automatic wr_mode(input logic [7:0] v);
		src.start;
		src.xfer({6'h1d, pin, 1'b0}, 1'b1, q, ak);
		src.xfer(8'h00, 1'b1, q, ak);
		src.xfer(v, 1'b1, q, ak);
		src.stop;
	endtask
	task automatic rd_mode;
		src.start;
		src.xfer({6'h1d, pin, 1'b0}, 1'b1, q, ak);
		src.xfer(8'h00, 1'b1, q, ak);
		src.start;
		src.xfer({6'h1d, pin, 1'b1}, 1'b1, q, ak);
		src.xfer(8'hff, 1'b1, q, ak);
		src.stop;
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// whole run is near 9800 clk; the 24000 clk limit means a hang
	initial begin
		#1200000;
		num_errors++;
		wrap_up;
	end
	initial begin
		src.w(6);
		reset = 1'b0;
		src.w(4);
		`CHK(display_on, 1'b0, "display on after reset")
		`CHK(pwr, 3'h2, "channel power")
		src.start;
		src.xfer(8'h74, 1'b1, q, ak);
		src.stop;
		`CHK(ak, 1'b1, "foreign address acked")
		wr_mode(8'h05);
		src.w(4);
		`CHK(display_on, 1'b1, "display not on")
		rd_mode;
		`CHK(q, 8'h05, "mode readback")
		src.pix(1'b0, 1'b0, 1'b1, 10'h000);
		src.pix(1'b0, 1'b1, 1'b0, 10'h000);
		`CHK(n_fs, 1, "frame start pulse")
		`CHK(n_ls, 1, "line start pulse")
		foreach (rows[i]) begin
			n0 = n_wr;
			src.pix(rows[i].de, 1'b0, 1'b0, rows[i].g);
			src.w(4);
			`CHK(n_wr != n0, rows[i].we, "write count")
			if (rows[i].we) begin
				`CHK(l_col, rows[i].col, "column")
				`CHK(l_top, rows[i].top, "column side")
				`CHK(l_row, 10'h014, "row")
				`CHK({l_r, l_b}, {2{rows[i].g}}, "sub-pixel copy")
				`CHK(l_g, rows[i].g, "green path")
			end
		end
		src.pix(1'b0, 1'b1, 1'b0, 10'h000);
		src.pix(1'b1, 1'b0, 1'b0, 10'h0f0);
		src.w(4);
		`CHK(l_row, 10'h015, "next line row")
		`CHK(l_col, 10'h014, "pixel count restart")
		enable = 1'b0;
		src.w(4);
		n0 = n_wr;
		src.pix(1'b1, 1'b0, 1'b0, 10'h0aa);
		src.w(4);
		`CHK(n_wr - n0, 0, "write while disabled")
		enable = 1'b1;
		bi = 1'b1;
		src.w(4);
		`CHK(burn_in_active, 1'b1, "burn-in flag")
		src.pix(1'b1, 1'b0, 1'b0, 10'h001);
		src.w(4);
		`CHK(l_g, 10'h3ff, "burn-in data")
		bi = 1'b0;
		wr_mode(8'h0f);
		src.pix(1'b0, 1'b0, 1'b1, 10'h000);
		src.w(4);
		`CHK(field_odd, 1'b1, "field toggle")
		src.pix(1'b0, 1'b1, 1'b0, 10'h000);
		src.pix(1'b1, 1'b0, 1'b0, 10'h3ff);
		src.w(4);
		`CHK(l_g, 10'h000, "pattern replaces video")
		`CHK(l_row, 10'h015, "interlaced row")
		// drop reset between edges: no clock may be needed
		@(posedge clk);
		#2 hw_reset_n = 1'b0;
		#10;
		`CHK(display_on, 1'b0, "async blank")
		`CHK(pwr, 3'h2, "async mode clear")
		src.w(2);
		hw_reset_n = 1'b1;
		src.w(4);
		src.pix(1'b1, 1'b0, 1'b0, 10'h155);
		src.w(4);
		`CHK(l_g, 10'h000, "data while display off")
		pin = 1'b0; // address pin always at a defined level
		src.w(4);
		src.start;
		src.xfer(8'h76, 1'b1, q, ak);
		src.stop;
		`CHK(ak, 1'b1, "old address acked")
		rd_mode;
		`CHK(q, 8'h04, "mode default")
		`CHK(display_on, 1'b0, "stays off")
		src.rb(10'h2aa, 10'h0f0);
		wr_mode(8'h31);
		`CHK(pwr, 3'h7, "colour power")
		src.pix(1'b1, 1'b0, 1'b0, 10'h155);
		src.w(4);
		`CHK({l_r, l_g, l_b}, {10'h2aa, 10'h155, 10'h0f0}, "colour buses")
		`CHK({l_col, l_row}, {10'h292, 10'h1f3}, "reversed scan")
		`CHK(l_top, 1'b1, "reversed column side")
		wrap_up;
	end
endmodule
`default_nettype wire
